// ==== core/ssw_alu_flags.sv ====
`timescale 1ns/1ps
// Computes result and zero, half-carry, carry flags of one ALU operation
module ssw_alu_flags
  import ssw_pkg::*;
(
  // Operation
  input wire ssw_pkg::ssw_op_t op,
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire logic cin_use,
  input wire logic cin,
  // Results
  output logic [7:0] result,
  output logic z,
  output logic dc,
  output logic c
);
  logic [4:0] lo_sum;
  logic [8:0] full_sum;
  logic [7:0] b_eff;
  logic cin_eff;
  // Subtract as a plus not-b plus one, or plus cin when cin_use is set, so carry out means no borrow
  assign b_eff = (op == SSW_OP_SUB) ? ~b : b;
  assign cin_eff = (op == SSW_OP_SUB) ? (cin_use ? cin : 1'b1)
                                      : (cin_use & cin);
  assign lo_sum = {1'b0, a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin_eff};
  assign full_sum = {1'b0, a} + {1'b0, b_eff} + {8'h00, cin_eff};
  // Result per operation
  always_comb begin
    result = a;
    c = cin;
    dc = 1'b0;
    case (op)
      SSW_OP_ADD, SSW_OP_SUB: begin
        result = full_sum[7:0];
        c = full_sum[8];
        dc = lo_sum[4];
      end
      SSW_OP_RR: begin
        result = {cin, a[7:1]};
        c = a[0];
      end
      SSW_OP_RL: begin
        result = {a[6:0], cin};
        c = a[7];
      end
      default: begin
        result = a;
      end
    endcase
  end
  assign z = (result == 8'h00);
endmodule : ssw_alu_flags

// ==== core/ssw_pkg.sv ====
package ssw_pkg;
  // Status register location and field positions
  localparam logic [4:0] SSW_STATUS_ADDR = 5'h03;
  localparam int SSW_PAGE_HI = 7;
  localparam int SSW_PAGE_LO = 5;
  localparam int SSW_TO_BIT = 4;
  localparam int SSW_PD_BIT = 3;
  localparam int SSW_Z_BIT = 2;
  localparam int SSW_DC_BIT = 1;
  localparam int SSW_C_BIT = 0;
  // Status value after power-up: timeout and power-down set, zero and carry flags clear, page 0
  localparam logic [7:0] SSW_STATUS_RST = 8'h18;
  // Selector codes for the port B auxiliary exchange
  localparam logic [7:0] SSW_SEL_PEND = 8'h09;
  localparam logic [7:0] SSW_SEL_EDGE = 8'h0A;
  localparam logic [7:0] SSW_SEL_EN = 8'h0B;
  localparam logic [7:0] SSW_SEL_DIR = 8'h0F;
  // Reset values of the wakeup and direction registers
  localparam logic [7:0] SSW_WAKE_RST = 8'hFF;
  localparam logic [7:0] SSW_PEND_RST = 8'h00;
  // Program page span and reset vector
  localparam logic [10:0] SSW_PAGE_SPAN = 11'h200;
  localparam logic [10:0] SSW_RESET_VECTOR = 11'h7FF;
  // ALU operation codes
  typedef enum logic [2:0] {
    SSW_OP_NONE = 3'b000,
    SSW_OP_ADD = 3'b001,
    SSW_OP_SUB = 3'b010,
    SSW_OP_RR = 3'b011,
    SSW_OP_RL = 3'b100,
    SSW_OP_LOGIC = 3'b101
  } ssw_op_t;
  // Power state
  typedef enum logic [0:0] {
    SSW_RUN = 1'b0,
    SSW_SLEEP = 1'b1
  } ssw_pwr_t;
endpackage : ssw_pkg

// ==== core/ssw_sync.sv ====
`timescale 1ns/1ps
// Two-stage synchroniser for one input bit
module ssw_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Data
  input wire logic d,
  output logic q
);
  logic meta_q;
  // First stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (reset) begin
      meta_q <= 1'b0;
      q <= 1'b0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule : ssw_sync

// ==== core/ssw_top.sv ====
`timescale 1ns/1ps
module ssw_top
  import ssw_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Status file register access
  input wire logic [4:0] file_addr,
  input wire logic file_we,
  input wire logic [7:0] file_wdata,
  output logic [7:0] status_rdata,
  // ALU operation completing this cycle
  input wire ssw_pkg::ssw_op_t alu_op,
  input wire logic [7:0] alu_a,
  input wire logic [7:0] alu_b,
  input wire logic carry_in_option,
  output logic [7:0] alu_result,
  // Flag updates from a logic operation writing only zero
  input wire logic logic_zero_upd,
  // Power and watchdog events
  input wire logic watchdog_kick_instruction,
  input wire logic halt_instruction,
  input wire logic watchdog_enable,
  input wire logic watchdog_overflow,
  input wire logic external_reset_pin,
  output logic watchdog_clear,
  output logic powered_down,
  output logic wake_restart,
  output logic [10:0] restart_vector,
  output logic [10:0] page_base,
  // Port B auxiliary exchange
  input wire logic [7:0] mode_select,
  input wire logic aux_write,
  input wire logic [7:0] aux_wdata,
  output logic [7:0] aux_rdata,
  // Port B wakeup pins
  input wire logic [7:0] port_b_pins,
  output logic [7:0] port_b_dir,
  output logic wake_interrupt
);
  logic [7:0] status_q;
  logic [7:0] status_d;
  logic [7:0] wake_enable_mask_q;
  logic [7:0] wake_edge_select_q;
  logic [7:0] wake_pending_latch_q;
  logic [7:0] wake_pending_latch_d;
  logic [7:0] port_b_dir_q;
  logic [7:0] aux_rdata_q;
  logic [7:0] pins_sync;
  logic [7:0] pins_prev_q;
  logic [7:0] rise;
  logic [7:0] fall;
  logic [7:0] edge_hit;
  logic [7:0] alu_res;
  logic alu_z;
  logic alu_dc;
  logic alu_c;
  logic status_wr;
  logic alu_flag_upd;
  logic sel_pend;
  logic sel_edge;
  logic sel_en;
  logic sel_dir;
  logic pin_wake;
  logic wake_now;
  ssw_pwr_t pwr_q;
  ssw_pwr_t pwr_d;
  logic wake_restart_q;
  logic [7:0] written_flags;
  logic [7:0] pin_hit;
  logic [7:0] aux_old;
  logic aux_take;
  logic run_state;
  logic asleep;
  logic halt_run;
  logic to_set;
  logic to_clr;
  logic pd_set;
  logic pd_clr;
  logic upd_z;
  logic upd_c;
  logic upd_dc;

  // One synchroniser per pin keeps edges clean across exchanges
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_sync
      ssw_sync u_sync (
        .clk(clk),
        .reset(reset),
        .d(port_b_pins[gi]),
        .q(pins_sync[gi])
      );
    end
  endgenerate

  // Shared flag computation
  ssw_alu_flags u_alu (
    .op(alu_op),
    .a(alu_a),
    .b(alu_b),
    .cin_use(~carry_in_option),
    .cin(status_q[SSW_C_BIT]),
    .result(alu_res),
    .z(alu_z),
    .dc(alu_dc),
    .c(alu_c)
  );
  assign alu_result = alu_res;

  // Power state views shared by the decode below
  assign run_state = (pwr_q == SSW_RUN);
  assign asleep = (pwr_q == SSW_SLEEP);

  // Edge detection on synchronised pins
  assign rise = pins_sync & ~pins_prev_q;
  assign fall = ~pins_sync & pins_prev_q;
  assign edge_hit = (wake_edge_select_q & fall)
                    | (~wake_edge_select_q & rise);
  assign pin_hit = edge_hit & ~wake_enable_mask_q;
  assign pin_wake = |pin_hit;

  // Selector decode for the auxiliary exchange
  assign sel_pend = aux_write && (mode_select == SSW_SEL_PEND);
  assign sel_edge = aux_write && (mode_select == SSW_SEL_EDGE);
  assign sel_en = aux_write && (mode_select == SSW_SEL_EN);
  assign sel_dir = aux_write && (mode_select == SSW_SEL_DIR);
  assign aux_take = sel_pend || sel_edge || sel_en || sel_dir;

  // Status write decode and flag sources
  assign status_wr = file_we && (file_addr == SSW_STATUS_ADDR);
  assign alu_flag_upd = (alu_op != SSW_OP_NONE);
  // Logic ops touch only zero; carry and half-carry keep their values
  assign upd_z = alu_flag_upd || logic_zero_upd;
  assign upd_c = alu_flag_upd && (alu_op != SSW_OP_LOGIC);
  assign upd_dc = (alu_op == SSW_OP_ADD) || (alu_op == SSW_OP_SUB);

  // Halt only counts while running; a halt seen during sleep is ignored
  assign halt_run = halt_instruction && run_state;
  // Timeout and power-down events; the status process orders them
  assign to_set = watchdog_kick_instruction || halt_run;
  assign to_clr = watchdog_overflow;
  assign pd_set = watchdog_kick_instruction;
  assign pd_clr = halt_run;

  // Pending latch: edges set bits; a pin event wins over the overwrite
  assign wake_pending_latch_d = (sel_pend ? aux_wdata : wake_pending_latch_q)
                                | edge_hit;

  // Wake decision
  assign wake_now = asleep
                    && (watchdog_overflow || pin_wake
                        || external_reset_pin);

  // Power state: halt enters sleep
  always_comb begin
    pwr_d = pwr_q;
    case (pwr_q)
      SSW_RUN: begin
        if (halt_instruction) begin
          pwr_d = SSW_SLEEP;
        end
      end
      SSW_SLEEP: begin
        if (wake_now) begin
          pwr_d = SSW_RUN;
        end
      end
      default: begin
        pwr_d = SSW_RUN;
      end
    endcase
  end

  // Written value merges, keeping the read-only timeout and power-down bits
  assign written_flags = {file_wdata[7:5], status_q[SSW_TO_BIT],
                          status_q[SSW_PD_BIT], file_wdata[2:0]};

  // Status next value; ALU completion overrides written flag bits
  always_comb begin
    status_d = status_q;
    if (status_wr) begin
      status_d = written_flags;
    end
    if (upd_z) begin
      status_d[SSW_Z_BIT] = alu_z;
    end
    if (upd_c) begin
      status_d[SSW_C_BIT] = alu_c;
    end
    if (upd_dc) begin
      status_d[SSW_DC_BIT] = alu_dc;
    end
    if (to_set) begin
      status_d[SSW_TO_BIT] = 1'b1;
    end
    if (pd_set) begin
      status_d[SSW_PD_BIT] = 1'b1;
    end
    // Halt comes after the kick, so a halt in the same cycle clears
    if (pd_clr) begin
      status_d[SSW_PD_BIT] = 1'b0;
    end
    // Watchdog overflow is the last word on the timeout flag
    if (to_clr) begin
      status_d[SSW_TO_BIT] = 1'b0;
    end
  end

  // Status register
  always_ff @(posedge clk) begin
    if (reset) begin
      status_q <= SSW_STATUS_RST;
    end else begin
      status_q <= status_d;
    end
  end

  // Power state register
  always_ff @(posedge clk) begin
    if (reset) begin
      pwr_q <= SSW_RUN;
    end else begin
      pwr_q <= pwr_d;
    end
  end

  // Previous synchronised level; reset low like the synchronisers, so
  // the first level after reset looks like a rise, which the reset edge
  // select ignores
  always_ff @(posedge clk) begin
    if (reset) begin
      pins_prev_q <= 8'h00;
    end else begin
      pins_prev_q <= pins_sync;
    end
  end

  // Pending latch follows its next value every cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      wake_pending_latch_q <= SSW_PEND_RST;
    end else begin
      wake_pending_latch_q <= wake_pending_latch_d;
    end
  end

  // Edge select, written only through its selector
  always_ff @(posedge clk) begin
    if (reset) begin
      wake_edge_select_q <= SSW_WAKE_RST;
    end else if (sel_edge) begin
      wake_edge_select_q <= aux_wdata;
    end
  end

  // Enable mask; all ones keeps every pin quiet until software opts in
  always_ff @(posedge clk) begin
    if (reset) begin
      wake_enable_mask_q <= SSW_WAKE_RST;
    end else if (sel_en) begin
      wake_enable_mask_q <= aux_wdata;
    end
  end

  // Direction register, reset to all inputs
  always_ff @(posedge clk) begin
    if (reset) begin
      port_b_dir_q <= SSW_WAKE_RST;
    end else if (sel_dir) begin
      port_b_dir_q <= aux_wdata;
    end
  end

  // Old contents picked by the selector; an unknown code takes nothing,
  // so the previous answer keeps standing
  assign aux_old = sel_pend ? wake_pending_latch_q
                   : sel_edge ? wake_edge_select_q
                   : sel_en ? wake_enable_mask_q
                   : port_b_dir_q;

  // Old contents returned on the same exchange that stores the new ones
  always_ff @(posedge clk) begin
    if (reset) begin
      aux_rdata_q <= 8'h00;
    end else if (aux_take) begin
      aux_rdata_q <= aux_old;
    end
  end

  // Restart pulse after a pin wakeup from sleep; watchdog and external
  // reset wakeups take their own paths and do not raise it
  always_ff @(posedge clk) begin
    if (reset) begin
      wake_restart_q <= 1'b0;
    end else begin
      wake_restart_q <= wake_now && pin_wake;
    end
  end

  // Outputs
  assign status_rdata = status_q;
  assign aux_rdata = aux_rdata_q;
  assign port_b_dir = port_b_dir_q;
  assign powered_down = asleep;
  assign wake_restart = wake_restart_q;
  assign restart_vector = SSW_RESET_VECTOR;
  // Page code times the page span; only codes 0..3 are meaningful
  assign page_base = SSW_PAGE_SPAN
                     * {8'h00, status_q[SSW_PAGE_HI:SSW_PAGE_LO]};
  // Kick always clears the watchdog; halt clears it only when it is on
  assign watchdog_clear = watchdog_kick_instruction
                          || (halt_run && watchdog_enable);
  // Interrupt only while running; asleep the same event wakes
  assign wake_interrupt = pin_wake && run_state;
endmodule : ssw_top

// ==== dv/ssw_assertions.sv ====
`timescale 1ns/1ps
// Port-level checks of status flags, power state and wakeup exchange
module ssw_assertions
  import ssw_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Status access
  input wire logic [4:0] file_addr,
  input wire logic file_we,
  input wire logic [7:0] status_rdata,
  // Power events
  input wire logic watchdog_kick_instruction,
  input wire logic halt_instruction,
  input wire logic watchdog_enable,
  input wire logic watchdog_overflow,
  input wire logic external_reset_pin,
  input wire logic watchdog_clear,
  input wire logic powered_down,
  input wire logic wake_restart,
  input wire logic [10:0] restart_vector,
  input wire logic [10:0] page_base,
  // Exchange and wakeup
  input wire logic [7:0] mode_select,
  input wire logic aux_write,
  input wire logic [7:0] aux_wdata,
  input wire logic [7:0] aux_rdata,
  input wire logic wake_interrupt
);
  // One domain, so clock and reset are given once
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // A quiet cycle keeps hardware events from masking a write
  wire logic quiet = !watchdog_kick_instruction && !halt_instruction
    && !watchdog_overflow && !external_reset_pin;
  ro_bits_a: assert property (
    file_we && file_addr == SSW_STATUS_ADDR && quiet
    |=> $stable(status_rdata[4:3])) else $error("status 4:3 took a write");
  kick_flags_a: assert property (
    watchdog_kick_instruction && !halt_instruction && !watchdog_overflow
    |=> status_rdata[4:3] == 2'b11)
    else $error("kick left flags wrong");
  halt_flags_a: assert property (
    halt_instruction && !powered_down && !watchdog_kick_instruction
    && !watchdog_overflow && !external_reset_pin
    |=> status_rdata[4:3] == 2'b10 && powered_down)
    else $error("halt left flags or power wrong");
  page_map_a: assert property (
    page_base == {status_rdata[6:5], 9'h000}) else $error("page base wrong");
  wdt_clear_a: assert property (
    watchdog_clear == (watchdog_kick_instruction
    || (halt_instruction && !powered_down && watchdog_enable)))
    else $error("watchdog clear wrong");
  wake_cause_a: assert property (
    $fell(powered_down) |-> wake_restart || $past(watchdog_overflow)
    || $past(external_reset_pin)) else $error("woke without cause");
  wake_vector_a: assert property (
    wake_restart |-> $past(powered_down) && !powered_down
    && restart_vector == SSW_RESET_VECTOR) else $error("bad wake restart");
  irq_run_a: assert property (
    wake_interrupt |-> !powered_down) else $error("interrupt while asleep");
  swap_old_a: assert property (
    aux_write && mode_select == SSW_SEL_EDGE ##1
    aux_write && mode_select == SSW_SEL_EDGE
    |=> aux_rdata == $past(aux_wdata, 2)) else $error("exchange lost value");
  // Main scenarios
  cover property (wake_restart);
  cover property (wake_interrupt);
  cover property (watchdog_overflow && powered_down);
endmodule : ssw_assertions

bind ssw_top ssw_assertions u_chk (.clk, .reset, .file_addr, .file_we,
  .status_rdata, .watchdog_kick_instruction, .halt_instruction,
  .watchdog_enable, .watchdog_overflow, .external_reset_pin,
  .watchdog_clear, .powered_down, .wake_restart, .restart_vector,
  .page_base, .mode_select, .aux_write, .aux_wdata, .aux_rdata,
  .wake_interrupt);

// ==== dv/ssw_pin_model.sv ====
`timescale 1ns/1ps
// Outside world on the port B pins; pull-ups hold them high at start
module ssw_pin_model (
  // Clock
  input wire logic clk,
  // Requested levels and pace
  input wire logic [7:0] target,
  input wire logic slow,
  // Pin levels
  output logic [7:0] pins
);
  int lag;
  initial pins = 8'hFF;
  initial lag = 0;
  // Move just after an edge; slow mode moves on the fourth edge, three cycles late, like a slow source
  always @(posedge clk) begin
    if (pins === target || !slow || lag == 3) begin
      pins <= target;
      lag <= 0;
    end else begin
      lag <= lag + 1;
    end
  end
endmodule : ssw_pin_model

// ==== dv/testbench.sv ====
`timescale 1ns/1ps
// Self-checking bench for status, sleep and wakeup
module testbench;
  import ssw_pkg::*;
  typedef struct {
    ssw_op_t op;
    logic [7:0] a, b, res;
    logic [2:0] f;
    logic zu;
  } ssw_row_t;
  logic clk = 0, reset = 1, file_we = 0, aux_write = 0, pin_slow = 0;
  logic carry_in_option = 1, logic_zero_upd = 0, watchdog_enable = 1;
  logic watchdog_kick_instruction = 0, halt_instruction = 0;
  logic watchdog_overflow = 0, external_reset_pin = 0, seen = 0;
  logic [4:0] file_addr = 5'h03;
  logic [7:0] file_wdata = 8'h00, alu_a = 8'h00, alu_b = 8'h00;
  logic [7:0] mode_select = 8'h00, aux_wdata = 8'h00, pin_tgt = 8'hFF;
  ssw_op_t alu_op = SSW_OP_NONE;
  wire logic [7:0] status_rdata, alu_result, aux_rdata, port_b_pins;
  wire logic [7:0] port_b_dir;
  wire logic watchdog_clear, powered_down, wake_restart, wake_interrupt;
  wire logic [10:0] restart_vector, page_base;
  int err_count = 0, comparisons = 0;
  // Flags are z, half carry, carry; rows chain through the carry
  ssw_row_t rows [9] = '{
    '{SSW_OP_ADD, 8'h0F, 8'h01, 8'h10, 3'b010, 1'b0},
    '{SSW_OP_ADD, 8'hFF, 8'h01, 8'h00, 3'b111, 1'b0},
    '{SSW_OP_SUB, 8'h10, 8'h01, 8'h0F, 3'b001, 1'b0},
    '{SSW_OP_SUB, 8'h05, 8'h05, 8'h00, 3'b111, 1'b0},
    '{SSW_OP_SUB, 8'h00, 8'h01, 8'hFF, 3'b000, 1'b0},
    '{SSW_OP_RR, 8'h81, 8'h00, 8'h40, 3'b001, 1'b0},
    '{SSW_OP_RL, 8'h80, 8'h00, 8'h01, 3'b001, 1'b0},
    '{SSW_OP_LOGIC, 8'h00, 8'h00, 8'h00, 3'b101, 1'b0},
    '{SSW_OP_NONE, 8'h01, 8'h00, 8'h01, 3'b001, 1'b1}};

  ssw_top dut (.clk, .reset, .file_addr, .file_we, .file_wdata,
    .status_rdata, .alu_op, .alu_a, .alu_b, .carry_in_option, .alu_result,
    .logic_zero_upd, .watchdog_kick_instruction, .halt_instruction,
    .watchdog_enable, .watchdog_overflow, .external_reset_pin,
    .watchdog_clear, .powered_down, .wake_restart, .restart_vector,
    .page_base, .mode_select, .aux_write, .aux_wdata, .aux_rdata,
    .port_b_pins, .port_b_dir, .wake_interrupt);
  ssw_pin_model pm (.clk, .target(pin_tgt), .slow(pin_slow),
    .pins(port_b_pins));

  // Clock at 100 MHz
  always #5 clk = ~clk;

  task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task end_sim;
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim

  // Status write; the strobe stays up for back-to-back calls, and the
  // caller drops it and any ALU op that finished in the same cycle
  task st_wr(input logic [7:0] d, input logic [7:0] exp);
    file_wdata = d;
    file_we = 1;
    @(negedge clk);
    chk("status", exp, status_rdata);
  endtask : st_wr

  // Exchange leaves the strobe up so calls can run back to back
  task xchg(input logic [7:0] sel, input logic [7:0] d, input logic [7:0] old);
    mode_select = sel;
    aux_wdata = d;
    aux_write = 1;
    @(negedge clk);
    chk("aux_old", old, aux_rdata);
  endtask : xchg

  task sleep_now;
    @(negedge clk) halt_instruction = 1;
    @(negedge clk) halt_instruction = 0;
  endtask : sleep_now

  task wait_pd(input logic lvl, input int n);
    for (int j = 0; j < n && powered_down !== lvl; j++) @(negedge clk);
    chk("powered_down", {7'h00, lvl}, {7'h00, powered_down});
  endtask : wait_pd

  // Main sequence
  initial begin
    repeat (8) @(negedge clk);
    reset = 0;
    chk("status_rst", SSW_STATUS_RST, status_rdata);
    chk("dir_rst", SSW_WAKE_RST, port_b_dir);
    foreach (rows[k]) begin
      alu_op = rows[k].op;
      alu_a = rows[k].a;
      alu_b = rows[k].b;
      logic_zero_upd = rows[k].zu;
      #1 chk("alu_result", rows[k].res, alu_result);
      @(negedge clk);
      chk("flags", {5'h03, rows[k].f}, status_rdata);
    end
    alu_op = SSW_OP_NONE;
    logic_zero_upd = 0;
    st_wr(8'h67, 8'h7F);
    chk("page", 8'h03, {6'h00, page_base[10:9]});
    alu_op = SSW_OP_ADD;
    st_wr(8'h07, 8'h18);
    alu_op = SSW_OP_NONE;
    st_wr(8'h01, 8'h19);
    file_addr = 5'h04;
    st_wr(8'h00, 8'h19);
    file_addr = 5'h03;
    file_we = 0;
    carry_in_option = 0;
    alu_op = SSW_OP_ADD;
    #1 chk("carry_in", 8'h02, alu_result);
    @(negedge clk);
    alu_op = SSW_OP_NONE;
    carry_in_option = 1;
    chk("carry_flags", 8'h18, status_rdata);
    // Configure in the safe order: edges, pending, enables
    xchg(SSW_SEL_EDGE, 8'h01, 8'hFF);
    xchg(SSW_SEL_EDGE, 8'hFF, 8'h01);
    xchg(SSW_SEL_PEND, 8'h00, SSW_PEND_RST);
    xchg(SSW_SEL_EN, 8'hFE, 8'hFF);
    xchg(SSW_SEL_DIR, 8'h07, 8'hFF);
    xchg(8'h05, 8'h33, 8'hFF);
    aux_write = 0;
    chk("dir", 8'h07, port_b_dir);
    pin_tgt = 8'hFE;
    repeat (8) @(negedge clk) seen = seen | wake_interrupt;
    chk("irq", 8'h01, {7'h00, seen});
    xchg(SSW_SEL_PEND, 8'h00, 8'h01);
    aux_write = 0;
    sleep_now();
    chk("to_pd", 8'h02, {6'h00, status_rdata[4:3]});
    // Unselected rise and a disabled pin must not wake; slow source
    pin_slow = 1;
    pin_tgt = 8'hFD;
    repeat (12) @(negedge clk);
    wait_pd(1, 1);
    pin_tgt = 8'hFC;
    seen = 0;
    repeat (12) @(negedge clk) seen = seen | wake_restart;
    wait_pd(0, 1);
    chk("restart", 8'h01, {7'h00, seen});
    chk("vector_hi", 8'h07, {5'h00, restart_vector[10:8]});
    chk("vector_lo", 8'hFF, restart_vector[7:0]);
    pin_slow = 0;
    @(negedge clk) watchdog_kick_instruction = 1;
    #1 chk("wdt_clear", 8'h01, {7'h00, watchdog_clear});
    @(negedge clk) watchdog_kick_instruction = 0;
    chk("to_pd", 8'h03, {6'h00, status_rdata[4:3]});
    sleep_now();
    @(negedge clk) watchdog_overflow = 1;
    @(negedge clk) watchdog_overflow = 0;
    wait_pd(0, 4);
    chk("to_pd", 8'h00, {6'h00, status_rdata[4:3]});
    watchdog_enable = 0;
    sleep_now();
    wait_pd(1, 2);
    external_reset_pin = 1;
    wait_pd(0, 8);
    external_reset_pin = 0;
    end_sim();
  end

  // Watchdog on the run
  initial begin
    #20000;
    err_count++;
    end_sim();
  end
endmodule : testbench
